/* hw/ssw_supervisor.sv */
// ssw_supervisor: reset supervisor with hold stretch, low-line warning
// and activity watchdog
// assumes comparator results and the kick line are synchronous to clk
`timescale 1ns/1ps

// What this block does
// - reset asserted at power-up, power-down, brownout
// - reset held while supply low or manual
// - active-high variant is exact inverse
// - warning low below low-line threshold
// - no kick edge for timeout triggers reset
// - hold and timeout fixed by parameters
// - hold option picks 1.4/28/200/1600 ms
module ssw_supervisor #(
  parameter logic ACTIVE_HIGH = 1'b0,
  parameter logic [1:0] HOLD_SEL = ssw_pkg::HOLD_SEL_DEF,
  parameter int unsigned WD_TIMEOUT_US = ssw_pkg::WD_TIMEOUT_US_DEF,
  parameter int unsigned TICK_CYCLES = ssw_pkg::TICK_CYCLES_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // comparator results and manual reset request
  input wire logic supplyOk,
  input wire logic supplyAboveLowLine,
  input wire logic manualResetIn,
  // processor activity
  input wire logic watchdogKickIn,
  // supervisor outputs
  output logic resetOut,
  output logic lowLineWarningN
);

  function automatic logic [ssw_pkg::CNT_W-1:0] holdTicks(
    input logic [1:0] sel
  );
    int unsigned us;
    case (sel)
      2'h0: us = ssw_pkg::HOLD_OPT0_US;
      2'h1: us = ssw_pkg::HOLD_OPT1_US;
      2'h2: us = ssw_pkg::HOLD_OPT2_US;
      2'h3: us = ssw_pkg::HOLD_OPT3_US;
      default: us = ssw_pkg::HOLD_OPT0_US;
    endcase
    return ssw_pkg::CNT_W'(us / ssw_pkg::TICK_US);
  endfunction

  localparam logic [ssw_pkg::CNT_W-1:0] HOLD_LAST =
    holdTicks(HOLD_SEL) - 24'h000001;
  localparam logic [ssw_pkg::CNT_W-1:0] WD_LAST =
    ssw_pkg::CNT_W'(WD_TIMEOUT_US / ssw_pkg::TICK_US - 1);
  localparam logic RST_ACTIVE = ACTIVE_HIGH;

  ssw_pkg::ssw_state_s s_r;
  ssw_pkg::ssw_state_s s_nxt;
  logic tick;
  logic divClr;
  logic kick;
  logic bad;

  // shared timebase
  ssw_tick_div #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_div (
    .clk(clk),
    .reset_n(reset_n),
    .clr(divClr),
    .tick(tick)
  );

  // outputs straight from the state register
  assign resetOut = s_r.resetOut;
  assign lowLineWarningN = s_r.lowLineN;

  // next state and counters
  always_comb begin
    s_nxt = s_r;
    divClr = 1'b0;
    s_nxt.kickPrev = watchdogKickIn;
    kick = watchdogKickIn != s_r.kickPrev;
    // any low supply or manual request
    bad = !supplyOk || manualResetIn;
    case (s_r.state)
      ssw_pkg::SSW_HOLD: begin
        s_nxt.holdCnt = '0;
        s_nxt.wdCnt = '0;
        if (!bad) begin
          s_nxt.state = ssw_pkg::SSW_STRETCH;
          divClr = 1'b1;
        end
      end
      ssw_pkg::SSW_STRETCH: begin
        s_nxt.wdCnt = '0;
        if (bad) begin
          s_nxt.state = ssw_pkg::SSW_HOLD;
          s_nxt.holdCnt = '0;
        end else if (tick) begin
          if (s_r.holdCnt == HOLD_LAST) begin
            s_nxt.state = ssw_pkg::SSW_RUN;
            s_nxt.holdCnt = '0;
            divClr = 1'b1;
          end else begin
            s_nxt.holdCnt = s_r.holdCnt + 24'h000001;
          end
        end
      end
      ssw_pkg::SSW_RUN: begin
        if (bad) begin
          s_nxt.state = ssw_pkg::SSW_HOLD;
          s_nxt.wdCnt = '0;
        end else if (kick) begin
          s_nxt.wdCnt = '0;
          divClr = 1'b1;
        end else if (tick) begin
          if (s_r.wdCnt == WD_LAST) begin
            s_nxt.state = ssw_pkg::SSW_STRETCH;
            s_nxt.wdCnt = '0;
            s_nxt.holdCnt = '0;
            divClr = 1'b1;
          end else begin
            s_nxt.wdCnt = s_r.wdCnt + 24'h000001;
          end
        end
      end
      default: begin
        s_nxt.state = ssw_pkg::SSW_HOLD;
        s_nxt.holdCnt = '0;
        s_nxt.wdCnt = '0;
      end
    endcase
    s_nxt.resetOut = (s_nxt.state != ssw_pkg::SSW_RUN) ? RST_ACTIVE
                                                       : !RST_ACTIVE;
    s_nxt.lowLineN = supplyAboveLowLine;
  end

  // state register, reset asserted from power-up
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r.state <= ssw_pkg::SSW_HOLD;
      s_r.holdCnt <= ssw_pkg::CNT_RST;
      s_r.wdCnt <= ssw_pkg::CNT_RST;
      s_r.kickPrev <= ssw_pkg::KICK_RST;
      s_r.resetOut <= RST_ACTIVE;
      s_r.lowLineN <= ssw_pkg::LOW_LINE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // assertion helper: cycles spent in the stretch state
  logic [31:0] stretchCyc;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stretchCyc <= 32'h00000000;
    end else if (s_r.state == ssw_pkg::SSW_STRETCH) begin
      stretchCyc <= stretchCyc + 32'h00000001;
    end else begin
      stretchCyc <= 32'h00000000;
    end
  end

  localparam logic [31:0] HOLD_CYC_LAST =
    32'(holdTicks(HOLD_SEL) * TICK_CYCLES - 1);

  property p_hold_while_bad;
    @(posedge clk) disable iff (!reset_n)
    (!supplyOk || manualResetIn) |=> resetOut == RST_ACTIVE;
  endproperty
  a_hold_while_bad: assert property (p_hold_while_bad)
    else $error("reset not asserted while supply or manual low");

  property p_release_after_hold;
    @(posedge clk) disable iff (!reset_n)
    (s_r.state == ssw_pkg::SSW_RUN &&
     $past(s_r.state) == ssw_pkg::SSW_STRETCH)
      |-> $past(stretchCyc) == HOLD_CYC_LAST;
  endproperty
  a_release_after_hold: assert property (p_release_after_hold)
    else $error("reset released before a full hold time");

  property p_polarity;
    @(posedge clk) disable iff (!reset_n)
    resetOut == (ACTIVE_HIGH ? (s_r.state != ssw_pkg::SSW_RUN)
                             : (s_r.state == ssw_pkg::SSW_RUN));
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("reset output polarity wrong for variant");

  property p_low_line;
    @(posedge clk) disable iff (!reset_n)
    !supplyAboveLowLine |=> !lowLineWarningN;
  endproperty
  a_low_line: assert property (p_low_line)
    else $error("warning not low below low-line threshold");

  property p_low_line_clear;
    @(posedge clk) disable iff (!reset_n)
    supplyAboveLowLine |=> lowLineWarningN;
  endproperty
  a_low_line_clear: assert property (p_low_line_clear)
    else $error("warning low above low-line threshold");

  property p_wd_trip;
    @(posedge clk) disable iff (!reset_n)
    (s_r.state == ssw_pkg::SSW_RUN && !bad && !kick && tick &&
     s_r.wdCnt == WD_LAST)
      |=> s_r.state == ssw_pkg::SSW_STRETCH ##1 resetOut == RST_ACTIVE;
  endproperty
  a_wd_trip: assert property (p_wd_trip)
    else $error("watchdog expiry did not trigger reset");

  property p_wd_restart;
    @(posedge clk) disable iff (!reset_n)
    (s_r.state == ssw_pkg::SSW_RUN && !bad && kick) |=> s_r.wdCnt == '0;
  endproperty
  a_wd_restart: assert property (p_wd_restart)
    else $error("watchdog not restarted by kick edge");

  property p_wd_held;
    @(posedge clk) disable iff (!reset_n)
    (s_r.state != ssw_pkg::SSW_RUN) |-> s_r.wdCnt == '0;
  endproperty
  a_wd_held: assert property (p_wd_held)
    else $error("watchdog counting while reset asserted");

  property p_brownout;
    @(posedge clk) disable iff (!reset_n)
    (s_r.state == ssw_pkg::SSW_RUN && !supplyOk)
      |=> s_r.state == ssw_pkg::SSW_HOLD ##1 resetOut == RST_ACTIVE;
  endproperty
  a_brownout: assert property (p_brownout)
    else $error("brownout did not assert reset");

endmodule // ssw_supervisor

/* hw/ssw_tick_div.sv */
// ssw_tick_div: free-running timebase, one-cycle tick every TICK_CYCLES
// assumes clr is a synchronous restart driven from the same clock
`timescale 1ns/1ps
module ssw_tick_div #(
  parameter int unsigned TICK_CYCLES = ssw_pkg::TICK_CYCLES_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // control
  input wire logic clr,
  // timebase
  output logic tick
);

  typedef struct packed {
    logic [ssw_pkg::DIV_W-1:0] cnt;
  } ssw_div_s;

  localparam logic [ssw_pkg::DIV_W-1:0] LAST =
    ssw_pkg::DIV_W'(TICK_CYCLES - 1);

  ssw_div_s s_r;
  ssw_div_s s_nxt;

  // tick marks the last cycle of each period; left ungated by clr,
  // since the user derives clr from tick and gating would close a loop
  assign tick = (s_r.cnt == LAST);

  // count up, wrap on tick, restart on clear
  always_comb begin
    s_nxt = s_r;
    if (clr || s_r.cnt == LAST) begin
      s_nxt.cnt = '0;
    end else begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule // ssw_tick_div

/* pkg/ssw_pkg.sv */
// ssw_pkg: constants, state encoding and state record of the supervisor
// assumes a single 100 MHz clock and digital comparator results at inputs
package ssw_pkg;

  // clock and timebase
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TICK_US = 100;
  localparam int unsigned TICK_CYCLES_DEF = TICK_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned DIV_W = 16;

  // reset hold time options, in microseconds
  localparam int unsigned HOLD_OPT0_US = 1400;
  localparam int unsigned HOLD_OPT1_US = 28000;
  localparam int unsigned HOLD_OPT2_US = 200000;
  localparam int unsigned HOLD_OPT3_US = 1600000;
  localparam logic [1:0] HOLD_SEL_DEF = 2'h0;

  // watchdog timeout default, microseconds (option value of our own)
  localparam int unsigned WD_TIMEOUT_US_DEF = 1600000;

  // timebase counter widths
  localparam int unsigned CNT_W = 24;

  // reset values
  localparam logic [CNT_W-1:0] CNT_RST = 24'h000000;
  localparam logic KICK_RST = 1'b0;
  localparam logic LOW_LINE_RST = 1'b0;

  typedef enum logic [1:0] {
    SSW_HOLD = 2'b00,
    SSW_STRETCH = 2'b01,
    SSW_RUN = 2'b10
  } ssw_state_e;

  typedef struct packed {
    ssw_state_e state;
    logic [CNT_W-1:0] holdCnt;
    logic [CNT_W-1:0] wdCnt;
    logic kickPrev;
    logic resetOut;
    logic lowLineN;
  } ssw_state_s;

endpackage

/* sim/ssw_cpu_model.sv */
// ssw_cpu_model: processor side that kicks the supervisor watchdog
// assumes the same clock as the supervisor; kicks only while kickEn
`timescale 1ns/1ps
module ssw_cpu_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // control from bench
  input wire logic kickEn,
  // activity line
  output logic watchdogKickIn
);
  logic [3:0] divCnt_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      divCnt_r <= 4'h0;
      watchdogKickIn <= 1'b0;
    end else if (kickEn) begin
      divCnt_r <= divCnt_r + 4'h1;
      if (divCnt_r == 4'hb) begin
        divCnt_r <= 4'h0;
        watchdogKickIn <= ~watchdogKickIn; // toggle every 12 cycles
      end
    end
  end
endmodule // ssw_cpu_model

/* sim/ssw_supervisor_bench.sv */
// ssw_supervisor_bench: directed tests of the supervisor
// assumes shortened timebase (4 cycles) and 8-tick watchdog timeout
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module ssw_supervisor_bench;
  localparam int TICK = 4;
  localparam int HOLD = ssw_pkg::HOLD_OPT0_US / ssw_pkg::TICK_US * TICK;
  localparam int WD_US = 800;
  localparam int WD = WD_US / ssw_pkg::TICK_US * TICK;
  localparam int HOLD_MID = ssw_pkg::HOLD_OPT1_US / ssw_pkg::TICK_US * TICK;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic supplyOk = 1'b0;
  logic lowOk = 1'b0;
  logic manualResetIn = 1'b0;
  logic kickEn = 1'b0;
  logic manualMid = 1'b1;
  logic rstMid;
  logic kick;
  logic rstLo;
  logic rstHi;
  logic llN;
  int err_count = 0;
  int comparisons = 0;
  int n;

  // clock, 10 ns period
  always #5 clk = ~clk;

  ssw_cpu_model u_cpu (.clk(clk), .reset_n(reset_n), .kickEn(kickEn),
    .watchdogKickIn(kick));
  ssw_supervisor #(.WD_TIMEOUT_US(WD_US),
    .TICK_CYCLES(TICK)) u_dut (.clk(clk), .reset_n(reset_n),
    .supplyOk(supplyOk), .supplyAboveLowLine(lowOk),
    .manualResetIn(manualResetIn), .watchdogKickIn(kick),
    .resetOut(rstLo), .lowLineWarningN(llN));
  ssw_supervisor #(.ACTIVE_HIGH(1'b1), .WD_TIMEOUT_US(WD_US),
    .TICK_CYCLES(TICK)) u_dut_hi (.clk(clk), .reset_n(reset_n),
    .supplyOk(supplyOk), .supplyAboveLowLine(lowOk),
    .manualResetIn(manualResetIn), .watchdogKickIn(kick),
    .resetOut(rstHi), .lowLineWarningN());
  // second hold option, kept in manual reset until its own test
  ssw_supervisor #(.HOLD_SEL(2'h1), .WD_TIMEOUT_US(WD_US),
    .TICK_CYCLES(TICK)) u_dut_mid (.clk(clk), .reset_n(reset_n),
    .supplyOk(supplyOk), .supplyAboveLowLine(lowOk),
    .manualResetIn(manualMid), .watchdogKickIn(kick),
    .resetOut(rstMid), .lowLineWarningN());

  // active-high variant mirrors the active-low one every cycle
  always @(negedge clk) begin
    if (reset_n) `CHK(rstHi, ~rstLo)
  end

  // counts edges while the low-active reset output stays at lvl
  task automatic span(input logic lvl, output int c);
    c = 0;
    do begin
      @(posedge clk);
      #1 c++;
    end while (rstLo === lvl && c < 2000);
  endtask

  task automatic tally_and_finish;
    $display("comparisons=%0d mismatches=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic t_powerup;
    @(posedge clk);
    supplyOk <= 1'b1;
    lowOk <= 1'b1;
    kickEn <= 1'b1;
    span(1'b0, n);
    `CHK(n, HOLD + 1)
    repeat (200) begin
      @(posedge clk);
      #1 `CHK(rstLo, 1'b1)
    end
    $display("power-up and kicking done");
  endtask

  task automatic t_manual;
    @(posedge clk);
    manualResetIn <= 1'b1;
    @(posedge clk);
    #1 `CHK(rstLo, 1'b0)
    repeat (20) @(posedge clk);
    #1 `CHK(rstLo, 1'b0)
    @(posedge clk);
    manualResetIn <= 1'b0;
    span(1'b0, n);
    `CHK(n, HOLD + 1)
    $display("manual reset done");
  endtask

  task automatic t_brownout;
    @(posedge clk);
    supplyOk <= 1'b0;
    @(posedge clk);
    supplyOk <= 1'b1;
    #1 `CHK(rstLo, 1'b0)
    repeat (30) @(posedge clk);
    supplyOk <= 1'b0;
    @(posedge clk);
    supplyOk <= 1'b1;
    span(1'b0, n);
    `CHK(n, HOLD + 1)
    $display("brownout done");
  endtask

  task automatic t_lowline;
    @(posedge clk);
    lowOk <= 1'b0;
    @(posedge clk);
    #1 `CHK(llN, 1'b0)
    `CHK(rstLo, 1'b1)
    @(posedge clk);
    lowOk <= 1'b1;
    @(posedge clk);
    #1 `CHK(llN, 1'b1)
    $display("low-line done");
  endtask

  task automatic t_watchdog;
    @(posedge clk);
    manualResetIn <= 1'b1;
    kickEn <= 1'b0;
    repeat (3) @(posedge clk);
    manualResetIn <= 1'b0;
    span(1'b0, n);
    span(1'b1, n);
    `CHK(n, WD)
    span(1'b0, n);
    `CHK(n, HOLD)
    $display("watchdog done");
  endtask

  // longer hold option measured on its own instance
  task automatic t_hold_opt;
    @(posedge clk);
    manualMid <= 1'b0;
    #1 `CHK(rstMid, 1'b0)
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (rstMid === 1'b0 && n < 2000);
    `CHK(n, HOLD_MID + 1)
    $display("hold option done");
  endtask

  // hang guard
  initial begin
    #50000;
    err_count++;
    tally_and_finish();
  end

  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1 `CHK(rstLo, 1'b0)
    t_powerup();
    t_manual();
    t_brownout();
    t_lowline();
    t_watchdog();
    t_hold_opt();
    tally_and_finish();
  end
endmodule // ssw_supervisor_bench
